//--- ivt_defines.svh
`ifndef IVT_DEFINES_SVH
`define IVT_DEFINES_SVH

// -------------------------------------------------------------
// sizes and control register layout
// -------------------------------------------------------------
`define SRC_COUNT     56
`define IC_IR_BIT     7
`define IC_IE_BIT     6
`define IC_PRIORITY_LEVEL_FIELD_LSB   2
`define IC_GROUP_LEVEL_FIELD_LSB   0
`define IC_RESET      8'h00
`define LVL_TRAP      4'hF

// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define OFF_IC_LAST   12'h0DC
`define OFF_TFR       12'h100
`define OFF_STAT      12'h104
`define OFF_MASK      12'h108
`define OFF_CORE      12'h10C
`define STAT_TRAP_BIT 0
`define STAT_INT_BIT  1
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

// -------------------------------------------------------------
// trap numbers
// -------------------------------------------------------------
`define TRAP_NMI      8'h02
`define TRAP_STKOF    8'h04
`define TRAP_STKUF    8'h06
`define TRAP_CLASSB   8'h0A
`define TN_CC0        8'h10
`define TN_CC16       8'h30
`define TN_CC29       8'h44
`define TN_T0         8'h20
`define TN_T1         8'h21
`define TN_T7         8'h3D
`define TN_T8         8'h3E
`define TN_T2         8'h22
`define TN_ADC        8'h28
`define TN_ADE        8'h29
`define TN_S0T        8'h2A
`define TN_S0TB       8'h47
`define TN_S0R        8'h2B
`define TN_S0E        8'h2C
`define TN_SCT        8'h2D
`define TN_PWM        8'h3F
`define TN_XP0        8'h40

`endif

//--- ivt_pkg.sv
package ivt_pkg;
	`include "ivt_defines.svh"

	typedef struct packed {
		logic        valid;
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} wr_req_s;

	typedef struct packed {
		logic        valid;
		logic [11:0] addr;
	} rd_req_s;

	typedef enum logic [2:0] {
		RD_IDLE  = 3'b001,
		RD_FETCH = 3'b010,
		RD_RESP  = 3'b100
	} rd_state_e;

	// 0 none, 1 class B, 2 class A
	typedef logic [1:0] trap_cls_t;

	// source index to trap number
	function automatic logic [7:0] trap_num_f(input logic [5:0] i);
		logic [7:0] n;
		n = {2'h0, i};
		if (i < 6'd16)      trap_num_f = `TN_CC0 + n;
		else if (i < 6'd29) trap_num_f = `TN_CC16 + n - 8'd16;
		else if (i < 6'd32) trap_num_f = `TN_CC29 + n - 8'd29;
		else if (i == 6'd32) trap_num_f = `TN_T0;
		else if (i == 6'd33) trap_num_f = `TN_T1;
		else if (i == 6'd34) trap_num_f = `TN_T7;
		else if (i == 6'd35) trap_num_f = `TN_T8;
		else if (i < 6'd42) trap_num_f = `TN_T2 + n - 8'd36;
		else if (i == 6'd42) trap_num_f = `TN_ADC;
		else if (i == 6'd43) trap_num_f = `TN_ADE;
		else if (i == 6'd44) trap_num_f = `TN_S0T;
		else if (i == 6'd45) trap_num_f = `TN_S0TB;
		else if (i == 6'd46) trap_num_f = `TN_S0R;
		else if (i == 6'd47) trap_num_f = `TN_S0E;
		else if (i < 6'd51) trap_num_f = `TN_SCT + n - 8'd48;
		else if (i == 6'd51) trap_num_f = `TN_PWM;
		else                 trap_num_f = `TN_XP0 + n - 8'd52;
	endfunction : trap_num_f

	// branch target is four times the trap number
	function automatic logic [23:0] vec_addr_f(input logic [7:0] t);
		vec_addr_f = {14'h0000, t, 2'b00};
	endfunction : vec_addr_f
endpackage : ivt_pkg

//--- ivt_axil_slave.sv
`timescale 1ns/1ps
module ivt_axil_slave
	import ivt_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output wr_req_s          wr_req,
	output rd_req_s          rd_req,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_err,
	input  wire logic        wr_err
);
	logic        aw_got_q, w_got_q;
	logic [11:0] awaddr_q, araddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	rd_state_e   rd_st_q, rd_st_d;

	// -------------------------------------------------------------
	// write channel: address and data in either order
	// -------------------------------------------------------------
	wire aw_take = awvalid & awready;
	wire w_take  = wvalid & wready;
	wire do_wr   = aw_got_q & w_got_q & ~bvalid;
	wire aw_got_d = (aw_got_q | aw_take) & ~do_wr;
	wire w_got_d  = (w_got_q | w_take) & ~do_wr;
	wire bvalid_d = do_wr | (bvalid & ~bready);

	assign wr_req = '{valid: do_wr, addr: awaddr_q, data: wdata_q, strb: wstrb_q};

	// ready stays low until the response is taken, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awready  <= 1'b0;
			wready   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= `RESP_OKAY;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q  <= w_got_d;
			awready  <= ~aw_got_d & ~bvalid_d;
			wready   <= ~w_got_d & ~bvalid_d;
			bvalid   <= bvalid_d;
			if (do_wr) bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
		end
	end

	// payload latches carry no reset
	always_ff @(posedge aclk) begin
		if (aw_take) awaddr_q <= awaddr;
		if (w_take) begin
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end
		if (arvalid && arready) araddr_q <= araddr;
	end

	// -------------------------------------------------------------
	// read channel
	// -------------------------------------------------------------
	assign rd_req = '{valid: rd_st_q == RD_FETCH, addr: araddr_q};

	always_comb begin
		rd_st_d = rd_st_q;
		unique case (rd_st_q)
			RD_IDLE:  if (arvalid) rd_st_d = RD_FETCH;
			RD_FETCH: rd_st_d = RD_RESP;
			RD_RESP:  if (rready) rd_st_d = RD_IDLE;
			default:  rd_st_d = RD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_st_q <= RD_IDLE;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end else begin
			rd_st_q <= rd_st_d;
			arready <= rd_st_d == RD_IDLE;
			rvalid  <= rd_st_d == RD_RESP;
			if (rd_st_q == RD_FETCH) begin
				rdata <= rd_data;
				rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
			end
		end
	end
endmodule : ivt_axil_slave

//--- ivt_prio_arbiter.sv
`timescale 1ns/1ps
module ivt_prio_arbiter #(
	parameter int N = 56
) (
	input  wire logic [N-1:0]      cand,
	input  wire logic [N-1:0][5:0] key,
	output logic [5:0]             win_idx,
	output logic [5:0]             win_key,
	output logic                   found
);
	// -------------------------------------------------------------
	// highest key wins, lower index breaks a full tie
	// -------------------------------------------------------------
	always_comb begin
		win_idx = 6'h00;
		win_key = 6'h00;
		found   = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (cand[i] && (!found || key[i] > win_key)) begin
				win_idx = 6'(i);
				win_key = key[i];
				found   = 1'b1;
			end
		end
	end
endmodule : ivt_prio_arbiter

//--- interrupt_vector_trap_map.sv
`timescale 1ns/1ps
// Summary of operation
// - every source has its own request flag, enable flag, vector and trap number
// - channels 0..15 use traps 10h..1Fh, vectors from 40h in steps of four
// - channels 16..28 use traps 30h..3Ch, channels 29..31 use 44h..46h
// - timers 0, 1, 7, 8 map to traps 20h, 21h, 3Dh, 3Eh
// - timers 2..6 map to 22h..26h, capture-reload source to 27h
// - converter complete at 28h, converter overrun at 29h
// - async channel transmit 2Ah, receive 2Bh, error 2Ch, buffer 47h
// - sync channel transmit, receive, error at 2Dh, 2Eh, 2Fh
// - pulse-width unit 3Fh, bus interfaces 40h/41h, flash 42h, clock monitor 43h
// - hardware traps dispatch at once, unmaskable; class A traps to their own vector, class B traps share 0Ah
// - each hardware trap sets its own trap flag bit
// - a trap pre-empts anything except a higher-priority trap service
// - no interrupt is offered during a trap service
// - control register low byte: flag 7, enable 6, level 5..2, group 1..0
// - sixteen levels; only a higher level interrupts a running service
module interrupt_vector_trap_map
	import ivt_pkg::*;
#(
	parameter int N_SRC = `SRC_COUNT
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [11:0]       awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [11:0]       araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [N_SRC-1:0]  src_evt,
	input  wire logic [7:0]        hw_trap_evt,
	input  wire logic [3:0]        cpu_level,
	input  wire logic              vec_accept,
	input  wire logic              trap_return,
	output logic                   vec_valid_q,
	output logic [7:0]             vec_trap_q,
	output logic [23:0]            vec_addr_q,
	output logic                   vec_is_trap_q,
	output logic [3:0]             vec_level_q,
	output logic                   irq_q
);
	// -------------------------------------------------------------
	// elaboration check
	// -------------------------------------------------------------
	if (N_SRC != `SRC_COUNT) begin : g_bad_n
		$error("source count must match the fixed trap map");
	end

	wr_req_s   wr;
	rd_req_s   rd;
	logic [31:0] rd_data;
	logic        rd_err, wr_err;

	logic [N_SRC-1:0][7:0] ic_q, ic_d;
	logic [7:0]  tfr_q, tfr_d;
	logic [7:0]  trap_pend_q, trap_pend_d;
	logic [1:0]  stat_q, stat_d;
	logic [1:0]  mask_q;
	trap_cls_t   trap_cls_q, trap_cls_d;
	trap_cls_t   vec_tcls_q;
	logic [7:0]  vec_tmask_q;
	logic [5:0]  sel_q;

	// -------------------------------------------------------------
	// bus slave
	// -------------------------------------------------------------
	ivt_axil_slave u_slave (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_req  (wr),
		.rd_req  (rd),
		.rd_data (rd_data),
		.rd_err  (rd_err),
		.wr_err  (wr_err)
	);

	// -------------------------------------------------------------
	// address decode
	// -------------------------------------------------------------
	function automatic logic ic_hit_f(input logic [11:0] a);
		ic_hit_f = (a[1:0] == 2'b00) && (a <= `OFF_IC_LAST);
	endfunction : ic_hit_f

	function automatic logic known_f(input logic [11:0] a);
		known_f = ic_hit_f(a) || a == `OFF_TFR || a == `OFF_STAT
			|| a == `OFF_MASK || a == `OFF_CORE;
	endfunction : known_f

	wire       wr_ic   = wr.valid & wr.strb[0] & ic_hit_f(wr.addr);
	wire [5:0] wr_idx  = wr.addr[7:2];
	wire       wr_tfr  = wr.valid & wr.strb[0] & (wr.addr == `OFF_TFR);
	wire       wr_mask = wr.valid & wr.strb[0] & (wr.addr == `OFF_MASK);
	wire       rd_stat = rd.valid & (rd.addr == `OFF_STAT);
	wire [5:0] rd_idx  = rd.addr[7:2];
	assign wr_err = ~known_f(wr.addr);
	assign rd_err = ~known_f(rd.addr);

	// upper bits of every register read as zero
	always_comb begin
		rd_data = 32'h0000_0000;
		if (ic_hit_f(rd.addr))
			rd_data[7:0] = ic_q[rd_idx];
		else if (rd.addr == `OFF_TFR)
			rd_data[7:0] = tfr_q;
		else if (rd.addr == `OFF_STAT)
			rd_data[1:0] = stat_q;
		else if (rd.addr == `OFF_MASK)
			rd_data[1:0] = mask_q;
		else if (rd.addr == `OFF_CORE)
			rd_data[7:0] = {vec_is_trap_q, vec_valid_q, 4'h0, trap_cls_q};
	end

	// -------------------------------------------------------------
	// interrupt arbitration
	// -------------------------------------------------------------
	logic [N_SRC-1:0]      cand;
	logic [N_SRC-1:0][5:0] key;
	logic [5:0]            win_idx, win_key;
	logic                  win_found;

	// flag and enable gate each source
	always_comb begin
		for (int i = 0; i < N_SRC; i++) begin
			cand[i] = ic_q[i][`IC_IR_BIT] & ic_q[i][`IC_IE_BIT];
			key[i]  = ic_q[i][5:0];
		end
	end

	ivt_prio_arbiter #(.N(N_SRC)) u_arb (
		.cand    (cand),
		.key     (key),
		.win_idx (win_idx),
		.win_key (win_key),
		.found   (win_found)
	);

	wire [3:0] win_lvl = win_key[5:2];
	// only a higher level than the running service
	wire lvl_ok = win_found & (win_lvl > cpu_level);
	// no interrupt offered during a trap service
	wire int_ok = lvl_ok & (trap_cls_q == 2'd0);

	// -------------------------------------------------------------
	// hardware trap selection
	// -------------------------------------------------------------
	// new events count at once so the trap is offered next cycle
	wire [7:0] pend_now = trap_pend_q | hw_trap_evt;
	wire       a_hit    = |pend_now[2:0];
	wire [7:0] t_num    = pend_now[0] ? `TRAP_NMI :
				pend_now[1] ? `TRAP_STKOF :
				pend_now[2] ? `TRAP_STKUF : `TRAP_CLASSB;
	wire [7:0] t_mask   = pend_now[0] ? 8'h01 :
				pend_now[1] ? 8'h02 :
				pend_now[2] ? 8'h04 : 8'hF8;
	wire trap_cls_t t_cls = a_hit ? 2'd2 : 2'd1;
	// blocked only by a higher trap class in service
	wire trap_ok  = (|pend_now) & (t_cls >= trap_cls_q);
	wire accepted = vec_accept & vec_valid_q;
	wire int_take = accepted & ~vec_is_trap_q;
	wire trp_take = accepted & vec_is_trap_q;

	// trap pending bits, no mask applies
	always_comb begin
		trap_pend_d = pend_now & ~(trp_take ? vec_tmask_q : 8'h00);
		trap_pend_d = trap_pend_d | hw_trap_evt;
	end

	// nesting depth is not kept: a return ends all trap service
	always_comb begin
		trap_cls_d = trap_cls_q;
		if (trap_return) trap_cls_d = 2'd0;
		if (trp_take) trap_cls_d = vec_tcls_q;
	end

	// -------------------------------------------------------------
	// control registers, set wins over any clear
	// -------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < N_SRC; i++) begin
			ic_d[i] = ic_q[i];
			if (wr_ic && wr_idx == 6'(i)) ic_d[i] = wr.data[7:0];
			if (int_take && sel_q == 6'(i)) ic_d[i][`IC_IR_BIT] = 1'b0;
			if (src_evt[i]) ic_d[i][`IC_IR_BIT] = 1'b1;
		end
	end

	// one flag bit per trap, write one to clear
	always_comb begin
		tfr_d = tfr_q & ~(wr_tfr ? wr.data[7:0] : 8'h00);
		tfr_d = tfr_d | hw_trap_evt;
	end

	// status cleared by its read, new events still land
	always_comb begin
		stat_d = rd_stat ? 2'b00 : stat_q;
		stat_d[`STAT_TRAP_BIT] = stat_d[`STAT_TRAP_BIT] | trp_take;
		stat_d[`STAT_INT_BIT]  = stat_d[`STAT_INT_BIT] | int_take;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ic_q        <= '{default: `IC_RESET};
			tfr_q       <= 8'h00;
			trap_pend_q <= 8'h00;
			trap_cls_q  <= 2'd0;
			stat_q      <= 2'b00;
			mask_q      <= 2'b00;
			irq_q       <= 1'b0;
		end else begin
			ic_q        <= ic_d;
			tfr_q       <= tfr_d;
			trap_pend_q <= trap_pend_d;
			trap_cls_q  <= trap_cls_d;
			stat_q      <= stat_d;
			if (wr_mask) mask_q <= wr.data[1:0];
			irq_q       <= |(stat_q & mask_q);
		end
	end

	// -------------------------------------------------------------
	// vector offer to the core
	// -------------------------------------------------------------
	// re-evaluated each cycle so a trap displaces an offered interrupt;
	// after an accept the offer drops one cycle for the level to settle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vec_valid_q   <= 1'b0;
			vec_is_trap_q <= 1'b0;
			vec_trap_q    <= 8'h00;
			vec_addr_q    <= 24'h000000;
			vec_level_q   <= 4'h0;
			vec_tcls_q    <= 2'd0;
			vec_tmask_q   <= 8'h00;
			sel_q         <= 6'h00;
		end else if (accepted) begin
			vec_valid_q <= 1'b0;
		end else if (trap_ok) begin
			vec_valid_q   <= 1'b1;
			vec_is_trap_q <= 1'b1;
			vec_trap_q    <= t_num;
			vec_addr_q    <= vec_addr_f(t_num);
			vec_level_q   <= `LVL_TRAP;
			vec_tcls_q    <= t_cls;
			vec_tmask_q   <= t_mask;
		end else begin
			vec_valid_q   <= int_ok;
			vec_is_trap_q <= 1'b0;
			vec_trap_q    <= trap_num_f(win_idx);
			vec_addr_q    <= vec_addr_f(trap_num_f(win_idx));
			vec_level_q   <= win_lvl;
			sel_q         <= win_idx;
		end
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_VEC_ADDR: assert property (
		vec_valid_q |-> vec_addr_q == {14'h0000, vec_trap_q, 2'b00}
	) else $error("vector address is not four times trap number");

	AST_INT_MAP: assert property (
		vec_valid_q && !vec_is_trap_q |-> vec_trap_q == trap_num_f(sel_q)
	) else $error("interrupt trap number does not match source");

	AST_TRAP_NOW: assert property (
		hw_trap_evt[0] && trap_cls_q == 2'd0 && !accepted && !trap_return
		|=> vec_valid_q && vec_is_trap_q && vec_trap_q == `TRAP_NMI
	) else $error("trap not offered on the next cycle");

	AST_TFR_SET: assert property (
		|hw_trap_evt |=> (tfr_q & $past(hw_trap_evt)) == $past(hw_trap_evt)
	) else $error("trap flag bit not set");

	AST_PREEMPT: assert property (
		hw_trap_evt[1] && trap_cls_q == 2'd1 && !accepted && !trap_return
		|=> vec_valid_q && vec_is_trap_q
	) else $error("class A trap did not pre-empt class B service");

	AST_NO_INT_IN_TRAP: assert property (
		trap_cls_q != 2'd0 |=> !(vec_valid_q && !vec_is_trap_q)
	) else $error("interrupt offered during trap service");

	AST_LEVEL: assert property (
		vec_valid_q && !vec_is_trap_q |-> vec_level_q > $past(cpu_level)
	) else $error("interrupt offered without higher level");

	AST_IR_SET: assert property (
		src_evt[5] |=> ic_q[5][`IC_IR_BIT] ##1 1'b1
	) else $error("event did not set request flag");

	AST_UPPER_ZERO: assert property (
		rd.valid && ic_hit_f(rd.addr) |=> rvalid && rdata[31:8] == 24'h000000
	) else $error("control register upper bits not zero");
endmodule : interrupt_vector_trap_map

//--- core_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// core side: takes offered vectors when allowed
// ---------------------------------------------------------------
module core_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       accept_en,
	input  wire logic       vec_valid_q,
	input  wire logic [7:0] vec_trap_q,
	output logic            vec_accept,
	output logic [7:0]      taken_trap,
	output int              n_taken
);
	// one pulse per offer; a slow core just keeps accept_en low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vec_accept <= 1'b0;
			taken_trap <= 8'h00;
			n_taken    <= 0;
		end else begin
			vec_accept <= accept_en & vec_valid_q & ~(vec_accept & vec_valid_q);
			if (vec_accept && vec_valid_q) begin
				taken_trap <= vec_trap_q;
				n_taken    <= n_taken + 1;
			end
		end
	end
endmodule : core_model

//--- interrupt_vector_trap_map_bench.sv
`timescale 1ns/1ps
module interrupt_vector_trap_map_bench;
	import ivt_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, d;
	logic [3:0]  wstrb = 4'h0, cpu_level = 4'h0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        accept_en = 0, trap_return = 0;
	logic [55:0] src_evt = '0;
	logic [7:0]  hw_trap_evt = 8'h00, taken_trap, vec_trap_q;
	logic        awready, wready, bvalid, arready, rvalid, vec_accept;
	logic        vec_valid_q, vec_is_trap_q, irq_q;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [23:0] vec_addr_q;
	logic [3:0]  vec_level_q;
	logic [11:0] rst_addr [6] = '{12'h000, 12'h0DC, 12'h100, 12'h104, 12'h108, 12'h10C};
	int          errors = 0, n_checks = 0, n_taken, i;
	always #5 aclk = ~aclk;
	interrupt_vector_trap_map dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .src_evt(src_evt), .hw_trap_evt(hw_trap_evt), .cpu_level(cpu_level),
		.vec_accept(vec_accept), .trap_return(trap_return), .vec_valid_q(vec_valid_q),
		.vec_trap_q(vec_trap_q), .vec_addr_q(vec_addr_q), .vec_is_trap_q(vec_is_trap_q),
		.vec_level_q(vec_level_q), .irq_q(irq_q));
	core_model core_u (.aclk(aclk), .aresetn(aresetn), .accept_en(accept_en),
		.vec_valid_q(vec_valid_q), .vec_trap_q(vec_trap_q), .vec_accept(vec_accept),
		.taken_trap(taken_trap), .n_taken(n_taken));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] exp_trap(input int s);
		if (s < 16) return 8'h10 + 8'(s);
		if (s < 29) return 8'h30 + 8'(s - 16);
		if (s < 32) return 8'h44 + 8'(s - 29);
		if (s < 34) return 8'h20 + 8'(s - 32);
		if (s < 36) return 8'h3D + 8'(s - 34);
		if (s < 45) return 8'h22 + 8'(s - 36);
		if (s == 45) return 8'h47;
		if (s < 48) return 8'h2B + 8'(s - 46);
		if (s < 51) return 8'h2D + 8'(s - 48);
		return 8'h3F + 8'(s - 51);
	endfunction : exp_trap
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	task automatic bail(input string what);
		errors++;
		$display("[ERR] %s expected answer seen timeout", what);
		conclude();
	endtask : bail
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : tick
	// bus master: offers address and data together, holds each until taken
	task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
		int k;
		bit ad, dd, bd;
		ad = 0; dd = 0; bd = 0;
		@(posedge aclk);
		awaddr <= a; wdata <= v; wstrb <= 4'hF;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (k = 0; k < 50 && !bd; k++) begin
			@(posedge aclk);
			if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
			if (wready && !dd) begin dd = 1; wvalid <= 1'b0; end
			if (bvalid) begin bd = 1; bready <= 1'b0; chk("bresp", er, bresp); end
		end
		if (!bd) bail("write");
	endtask : axw
	task automatic axr(input logic [11:0] a, output logic [31:0] v, input logic [1:0] er);
		int k;
		bit ad, rd;
		ad = 0; rd = 0; v = '0;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (k = 0; k < 50 && !rd; k++) begin
			@(posedge aclk);
			if (arready && !ad) begin ad = 1; arvalid <= 1'b0; end
			if (rvalid) begin rd = 1; rready <= 1'b0; v = rdata; chk("rresp", er, rresp); end
		end
		if (!rd) bail("read");
	endtask : axr
	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] v;
		axr(a, v, 2'h0);
		chk(n, e, v);
	endtask : rchk
	task automatic fire(input logic [55:0] s, input logic [7:0] h);
		@(posedge aclk);
		src_evt <= s; hw_trap_evt <= h;
		@(posedge aclk);
		src_evt <= '0; hw_trap_evt <= 8'h00;
	endtask : fire
	task automatic wait_vec();
		int k;
		for (k = 0; k < 20 && vec_valid_q !== 1'b1; k++) tick(1);
		if (vec_valid_q !== 1'b1) bail("vector offer");
	endtask : wait_vec
	task automatic take();
		int k, n0;
		n0 = n_taken;
		@(posedge aclk);
		accept_en <= 1'b1;
		for (k = 0; k < 20 && n_taken == n0; k++) @(posedge aclk);
		accept_en <= 1'b0;
		if (n_taken == n0) bail("accept");
	endtask : take
	task automatic ret();
		@(posedge aclk);
		trap_return <= 1'b1;
		@(posedge aclk);
		trap_return <= 1'b0;
	endtask : ret
	task automatic chk_vec(input logic [7:0] t, input logic tr, input logic [3:0] lv);
		wait_vec();
		chk("trap number", t, vec_trap_q);
		chk("vector", {t, 2'b00}, vec_addr_q);
		chk("is trap", tr, vec_is_trap_q);
		chk("level", lv, vec_level_q);
	endtask : chk_vec
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		tick(2);
		foreach (rst_addr[k]) rchk("reset value", rst_addr[k], 32'h0);
		axr(12'h200, d, 2'h2);
		chk("unmapped data", 32'h0, d);
		axw(12'h200, 32'h1, 2'h2);
		// every source: own flag, enable, trap number and vector
		for (i = 0; i < 56; i++) begin
			axw(12'(4 * i), 32'h44, 2'h0);
			fire(56'(1) << i, 8'h00);
			chk_vec(exp_trap(i), 1'b0, 4'h1);
			take();
			chk("taken", exp_trap(i), taken_trap);
			rchk("flag cleared", 12'(4 * i), 32'h44);
		end
		// layout, upper byte zero, disabled source holds its flag only
		axw(12'h00C, 32'hFFFF_FF3C, 2'h0);
		fire(56'h8, 8'h00);
		tick(5);
		chk("disabled offer", 1'b0, vec_valid_q);
		rchk("ctrl layout", 12'h00C, 32'hBC);
		axw(12'h00C, 32'h0, 2'h0);
		// levels, groups and the running level
		cpu_level <= 4'h3;
		axw(12'h000, 32'h4C, 2'h0);
		axw(12'h004, 32'h55, 2'h0);
		axw(12'h008, 32'h56, 2'h0);
		fire(56'h1, 8'h00);
		tick(5);
		chk("equal level", 1'b0, vec_valid_q);
		fire(56'h6, 8'h00);
		chk_vec(8'h12, 1'b0, 4'h5);
		take();
		chk_vec(8'h11, 1'b0, 4'h5);
		take();
		cpu_level <= 4'h2;
		chk_vec(8'h10, 1'b0, 4'h3);
		take();
		cpu_level <= 4'h0;
		// status and mask drive the interrupt line
		axw(12'h108, 32'h1, 2'h0);
		tick(2);
		chk("irq masked", 1'b0, irq_q);
		axw(12'h108, 32'h3, 2'h0);
		tick(2);
		chk("irq", 1'b1, irq_q);
		rchk("status", 12'h104, 32'h2);
		tick(2);
		chk("irq after read", 1'b0, irq_q);
		// class A traps each on their own vector
		for (i = 0; i < 3; i++) begin
			fire(56'h0, 8'(1 << i));
			chk_vec(8'(2 + 2 * i), 1'b1, 4'hF);
			take();
			ret();
		end
		rchk("trap flags", 12'h100, 32'h7);
		axw(12'h100, 32'h7, 2'h0);
		// trap pre-empts a pending offer, then holds off interrupts and class B
		axw(12'h010, 32'h48, 2'h0);
		fire(56'h10, 8'h00);
		chk_vec(8'h14, 1'b0, 4'h2);
		fire(56'h0, 8'h01);
		tick(1);
		chk_vec(8'h02, 1'b1, 4'hF);
		take();
		fire(56'h0, 8'h08);
		tick(5);
		chk("held in trap", 1'b0, vec_valid_q);
		rchk("service class", 12'h10C, 32'h2);
		rchk("trap flags", 12'h100, 32'h9);
		ret();
		chk_vec(8'h0A, 1'b1, 4'hF);
		take();
		tick(5);
		chk("held in class B", 1'b0, vec_valid_q);
		ret();
		chk_vec(8'h14, 1'b0, 4'h2);
		take();
		axw(12'h100, 32'h9, 2'h0);
		rchk("trap flags cleared", 12'h100, 32'h0);
		rchk("status both", 12'h104, 32'h3);
		conclude();
	end
endmodule : interrupt_vector_trap_map_bench
